// *** rtl/tal_pkg.sv ***
// Shared constants and types of the temperature alarm and pin address block
package tal_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_MASK = 8'h01;
   localparam logic [7:0] OFF_UPPER_HI = 8'h10;
   localparam logic [7:0] OFF_UPPER_LO = 8'h11;
   localparam logic [7:0] OFF_LOWER_HI = 8'h12;
   localparam logic [7:0] OFF_LOWER_LO = 8'h13;
   localparam logic [7:0] OFF_PIN_CFG = 8'h20;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int OVER_BIT = 1;
   localparam int UNDER_BIT = 2;
   localparam int INT_MODE_LSB = 0;
   localparam int INT_LEVEL_BIT = 2;
   localparam int TRIG_LEVEL_BIT = 3;
   localparam int TRIG_MODE_LSB = 6;
   localparam logic [7:0] ALARM_BITS = 8'h06;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] UPPER_RST = 16'h7FFF;
   localparam logic [15:0] LOWER_RST = 16'h8000;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] PIN_CFG_RST = 8'h82;
   // ----------------------------------------
   // Pin modes and serial framing
   // ----------------------------------------
   localparam logic [1:0] MODE_HIZ = 2'h0;
   localparam logic [1:0] MODE_OUT = 2'h1;
   localparam logic [1:0] MODE_PULLDOWN = 2'h2;
   localparam logic [1:0] MODE_FUNC = 2'h3;
   localparam logic [4:0] ADDR_PREFIX = 5'h14;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD, ST_SKIP
   } tal_state_t;
endpackage

// *** rtl/tal_link_if.sv ***
// Signals between the serial clock domain and the core clock domain
interface tal_link_if;
   logic rx_tgl;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic ack_en;
   logic tx_act;
   modport link (output rx_tgl, output rx_byte, input tx_byte, input ack_en, input tx_act);
   modport core (input rx_tgl, input rx_byte, output tx_byte, output ack_en, output tx_act);
endinterface

// *** rtl/tal_link.sv ***
// Bit shifter of the serial target, clocked by the host's serial clock
module tal_link
   import tal_pkg::*;
(
   input wire logic scl,        // Serial clock from the host
   input wire logic arst_n,     // Power-on reset
   input wire logic frm_rst_n,  // Frame restart at START and STOP
   input wire logic sda_in,     // Data line level
   output logic sda_oe,         // Pull data line low
   tal_link_if.link lk          // Byte exchange with the core
);
   logic [3:0] bitcnt;
   logic [6:0] shreg;
   logic sending;

   // ----------------------------------------
   // Rising edge: sample data, count bits
   // ----------------------------------------
   always_ff @(posedge scl or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         bitcnt <= 4'h0;
         sending <= 1'b0;
      end else if (bitcnt == ACK_SLOT) begin
         bitcnt <= 4'h0;
         // Host ack keeps a read going, a nack ends it
         sending <= sending ? ~sda_in : lk.tx_act;
      end else begin
         bitcnt <= bitcnt + 4'h1;
      end
   end

   // The toggle survives frame restarts so the core never sees a false byte
   always_ff @(posedge scl or negedge arst_n) begin
      if (!arst_n) begin
         shreg <= 7'h00;
         lk.rx_byte <= 8'h00;
         lk.rx_tgl <= 1'b0;
      end else if (bitcnt < ACK_SLOT) begin
         shreg <= {shreg[5:0], sda_in};
         if (bitcnt == LAST_DATA_BIT) begin
            lk.rx_byte <= {shreg, sda_in};
            lk.rx_tgl <= ~lk.rx_tgl;
         end
      end
   end

   // ----------------------------------------
   // Falling edge: drive ack or read data
   // ----------------------------------------
   // Open drain only: the line is pulled low or released, never driven high
   always_ff @(negedge scl or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         sda_oe <= 1'b0;
      end else if (bitcnt == ACK_SLOT) begin
         sda_oe <= ~sending & lk.ack_en;
      end else begin
         sda_oe <= sending & ~lk.tx_byte[~bitcnt[2:0]];
      end
   end

   AST_BIT_WRAP: assert property (@(posedge scl) disable iff (!frm_rst_n)
      bitcnt == ACK_SLOT |=> bitcnt == 4'h0)
      else $error("bit counter did not wrap after the ack slot");
endmodule // tal_link

// *** rtl/tal_alarm.sv ***
// Temperature alarm, pin mode and serial register target of the sensor
// How it works
// - Compare each finished result with both limits
// - Limits reset to 7FFF and 8000
// - Upper limit bytes at 10 and 11
// - Lower limit bytes at 12 and 13
// - Below lower sets under, above upper over
// - Interrupt needs flag, enable and mode 3
// - Only a status read clears flags; it or a mask or mode write drops interrupt
// - Set flags stay set on good results
// - Trigger mode, falling pin edge starts conversion
// - Mode field picks pin function
// - Both pins power up in pulldown mode
// - Pins sampled at START give address bits
// - Address is 10100, pin bits, direction
// - Output or function mode forces address bit low
// - Serial link runs on host clock, 400kHz
// - Bytes are eight bits plus ack
// - Read data follows host clock edges
// - Data line open drain, clock input only
// - Results and limits are 16-bit signed
module tal_alarm
   import tal_pkg::*;
(
   input wire logic core_clk,             // 10 MHz core clock
   input wire logic arst_n,               // Asynchronous reset
   input wire logic scl,                  // Serial clock pin
   input wire logic sda_i,                // Serial data pin level
   output logic sda_o,                    // Serial data drive level
   output logic sda_oe,                   // Serial data pull-low enable
   input wire logic int_i,                // Interrupt pin level
   output logic int_o,                    // Interrupt pin drive level
   output logic int_oe,                   // Interrupt pin drive enable
   output logic int_pd,                   // Interrupt pin pulldown on
   input wire logic trig_i,               // Trigger pin level
   output logic trig_o,                   // Trigger pin drive level
   output logic trig_oe,                  // Trigger pin drive enable
   output logic trig_pd,                  // Trigger pin pulldown on
   input wire logic start_measure_fn_done,            // Conversion finished pulse
   input wire logic [15:0] start_measure_fn_result,   // Finished conversion result
   output logic start_measure_fn_start                // Start conversion pulse
);
   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [7:0] status;
   logic [7:0] mask;
   logic [15:0] upper_limit;
   logic [15:0] lower_limit;
   logic [7:0] pin_cfg_reg;
   logic [7:0] ptr;
   logic [7:0] tx_byte;
   logic [1:0] addr_bits;
   logic ack_en;
   logic tx_act;
   logic fresh;
   logic frm_rst_n;
   tal_state_t state;

   logic scl_m, scl_s, sda_m, sda_s, sda_d;
   logic int_m, int_s, trig_m, trig_s, trig_d;
   logic tgl_m, tgl_s, tgl_d;

   tal_link_if lnk();

   tal_link u_link (
      .scl(scl),
      .arst_n(arst_n),
      .frm_rst_n(frm_rst_n),
      .sda_in(sda_i),
      .sda_oe(sda_oe),
      .lk(lnk.link)
   );

   assign lnk.tx_byte = tx_byte;
   assign lnk.ack_en = ack_en;
   assign lnk.tx_act = tx_act;
   // The data line is only ever pulled low
   assign sda_o = 1'b0;

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [7:0] st,
         input logic [7:0] mk, input logic [15:0] up, input logic [15:0] lo,
         input logic [7:0] cfg);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         OFF_STATUS: d = st;
         OFF_MASK: d = mk;
         OFF_UPPER_HI: d = up[15:8];
         OFF_UPPER_LO: d = up[7:0];
         OFF_LOWER_HI: d = lo[15:8];
         OFF_LOWER_LO: d = lo[7:0];
         OFF_PIN_CFG: d = cfg;
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         {scl_m, scl_s, sda_m, sda_s, sda_d} <= 5'h1F;
         // Pins start in pulldown mode, so a low pin gives no false trigger edge
         {int_m, int_s, trig_m, trig_s, trig_d} <= 5'h00;
         {tgl_m, tgl_s, tgl_d} <= 3'h0;
      end else begin
         {scl_m, scl_s} <= {scl, scl_m};
         {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
         {int_m, int_s} <= {int_i, int_m};
         {trig_m, trig_s, trig_d} <= {trig_i, trig_m, trig_s};
         {tgl_m, tgl_s, tgl_d} <= {lnk.rx_tgl, tgl_m, tgl_s};
      end
   end

   // ----------------------------------------
   // Decode of frame and register events
   // ----------------------------------------
   wire [1:0] int_mode = pin_cfg_reg[INT_MODE_LSB +: 2];
   wire [1:0] trig_mode = pin_cfg_reg[TRIG_MODE_LSB +: 2];
   wire start_ev = scl_s & sda_d & ~sda_s;
   wire stop_ev = scl_s & ~sda_d & sda_s;
   wire byte_ev = tgl_s ^ tgl_d;
   wire [7:0] rx_byte = lnk.rx_byte;
   // Output and function modes force the address bit low
   wire int_abit = int_s & ~int_mode[0];
   wire trig_abit = trig_s & ~trig_mode[0];
   wire addr_hit = rx_byte[7:1] == {ADDR_PREFIX, addr_bits};
   wire is_read = rx_byte[0];
   wire [7:0] ptr_rd = (is_read && fresh) ? OFF_STATUS : ptr;
   wire [7:0] ptr_inc = ptr + 8'h01;
   wire wr_ev = byte_ev && state == ST_WR;
   wire rd_ev = byte_ev && state == ST_RD;
   // A status byte handed to the host clears the flags
   wire stat_clr = rd_ev && ptr == OFF_STATUS;
   wire over_hit = start_measure_fn_done && $signed(start_measure_fn_result) > $signed(upper_limit);
   wire under_hit = start_measure_fn_done && $signed(start_measure_fn_result) < $signed(lower_limit);
   wire [7:0] stat_set = ({7'h00, over_hit} << OVER_BIT) | ({7'h00, under_hit} << UNDER_BIT);
   // Only bits already shifted out are cleared, so a flag raised mid-read survives.
   // Set wins over clear, and good results never clear a flag.
   wire [7:0] next_status = (status & ~(stat_clr ? tx_byte : 8'h00)) | stat_set;
   wire irq_on = |(status & mask & ALARM_BITS) && int_mode == MODE_FUNC;
   wire trig_fall = trig_d & ~trig_s;

   // ----------------------------------------
   // Alarm status
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask <= MASK_RST;
         upper_limit <= UPPER_RST;
         lower_limit <= LOWER_RST;
         pin_cfg_reg <= PIN_CFG_RST;
      end else if (wr_ev) begin
         case (ptr)
            OFF_MASK: mask <= rx_byte;
            OFF_UPPER_HI: upper_limit[15:8] <= rx_byte;
            OFF_UPPER_LO: upper_limit[7:0] <= rx_byte;
            OFF_LOWER_HI: lower_limit[15:8] <= rx_byte;
            OFF_LOWER_LO: lower_limit[7:0] <= rx_byte;
            OFF_PIN_CFG: pin_cfg_reg <= rx_byte;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Serial frame control
   // ----------------------------------------
   // A one-cycle restart at START and STOP puts the link back to bit zero.
   // The edge comes while the serial clock is high, well clear of its next edge.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         frm_rst_n <= 1'b0;
      end else begin
         frm_rst_n <= ~(start_ev | stop_ev);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_bits <= 2'h0;
      end else if (start_ev) begin
         addr_bits <= {trig_abit, int_abit};
      end
   end

   // Ack and transmit decisions must settle within one clock-high phase;
   // the sync path takes three core cycles, inside the 0.6 us of a 400kHz bus.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         ack_en <= 1'b0;
         tx_act <= 1'b0;
         fresh <= 1'b1;
      end else if (start_ev) begin
         state <= ST_ADDR;
         ack_en <= 1'b0;
         tx_act <= 1'b0;
      end else if (stop_ev) begin
         state <= ST_IDLE;
         ack_en <= 1'b0;
         tx_act <= 1'b0;
         fresh <= 1'b1;
      end else if (byte_ev) begin
         unique case (state)
            ST_ADDR: begin
               ack_en <= addr_hit;
               tx_act <= addr_hit & is_read;
               if (addr_hit) begin
                  fresh <= 1'b0;
                  state <= is_read ? ST_RD : ST_PTR;
               end else begin
                  state <= ST_SKIP;
               end
            end
            ST_PTR: state <= ST_WR;
            ST_IDLE, ST_WR, ST_RD, ST_SKIP: ;
         endcase
      end
   end

   // ----------------------------------------
   // Register pointer and read data
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr <= OFF_STATUS;
         tx_byte <= 8'h00;
      end else if (byte_ev && state == ST_ADDR && addr_hit && is_read) begin
         // A read after STOP starts at status; after a repeated START it keeps the pointer
         ptr <= ptr_rd;
         tx_byte <= rd_reg(ptr_rd, status, mask, upper_limit, lower_limit, pin_cfg_reg);
      end else if (byte_ev && state == ST_PTR) begin
         ptr <= rx_byte;
      end else if (wr_ev) begin
         ptr <= ptr_inc;
      end else if (rd_ev) begin
         // Loaded while the last bit's clock is high, shifted out from the falling edge after the ack slot
         ptr <= ptr_inc;
         tx_byte <= rd_reg(ptr_inc, next_status, mask, upper_limit, lower_limit,
            pin_cfg_reg);
      end
   end

   // ----------------------------------------
   // Pins and conversion trigger
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_o <= 1'b0;
         int_oe <= 1'b0;
         int_pd <= 1'b1;
         trig_o <= 1'b0;
         trig_oe <= 1'b0;
         trig_pd <= 1'b1;
         start_measure_fn_start <= 1'b0;
      end else begin
         // Function mode pulls the pin low while the interrupt stands
         int_o <= (int_mode == MODE_OUT) & pin_cfg_reg[INT_LEVEL_BIT];
         int_oe <= (int_mode == MODE_OUT) | irq_on;
         int_pd <= int_mode == MODE_PULLDOWN;
         trig_o <= (trig_mode == MODE_OUT) & pin_cfg_reg[TRIG_LEVEL_BIT];
         trig_oe <= trig_mode == MODE_OUT;
         trig_pd <= trig_mode == MODE_PULLDOWN;
         // One start for each fall, so a held-low pin does not retrigger
         start_measure_fn_start <= trig_fall && trig_mode == MODE_FUNC;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   AST_OVER_SET: assert property (
      start_measure_fn_done && $signed(start_measure_fn_result) > $signed(upper_limit) |=> status[OVER_BIT])
      else $error("over flag not set after a result above the upper limit");

   AST_UNDER_SET: assert property (
      start_measure_fn_done && $signed(start_measure_fn_result) < $signed(lower_limit) |=> status[UNDER_BIT])
      else $error("under flag not set after a result below the lower limit");

   AST_STICKY_OVER: assert property (
      $fell(status[OVER_BIT]) |-> $past(stat_clr))
      else $error("over flag cleared without a status read");

   AST_STICKY_UNDER: assert property (
      !stat_clr && status[UNDER_BIT] |=> status[UNDER_BIT])
      else $error("under flag dropped without a status read");

   AST_IRQ_GATE: assert property (
      int_oe && $past(int_mode) == MODE_FUNC |-> $past(|(status & mask & ALARM_BITS)))
      else $error("interrupt asserted without an enabled flag");

   AST_IRQ_LOW: assert property (
      irq_on ##1 $stable(pin_cfg_reg) |-> int_oe && !int_o)
      else $error("interrupt pin not pulled low while active");

   AST_TRIG_START: assert property (
      trig_fall && trig_mode == MODE_FUNC |=> start_measure_fn_start ##1 !start_measure_fn_start)
      else $error("trigger fall did not give one start pulse");

   AST_ADDR_FORCE: assert property (
      start_ev && int_mode[0] |=> addr_bits[0] == 1'b0)
      else $error("address bit not forced low in output or function mode");

   AST_ADDR_ACK: assert property (
      byte_ev && state == ST_ADDR && !start_ev && !stop_ev |=>
         ack_en == ($past(rx_byte[7:1]) == {ADDR_PREFIX, addr_bits}))
      else $error("address ack does not match the sampled pin address");

   AST_UNDER_CLR: assert property (
      $fell(status[UNDER_BIT]) |-> $past(stat_clr))
      else $error("under flag cleared without a status read");

   AST_IRQ_DROP: assert property (
      !irq_on && int_mode != MODE_OUT |=> !int_oe)
      else $error("interrupt pin driven without an enabled flag");

   AST_TRIG_MODE: assert property (
      start_measure_fn_start |-> $past(trig_mode) == MODE_FUNC)
      else $error("conversion started outside trigger mode");

   AST_LIMIT_HOLD: assert property (
      !wr_ev |=> $stable(upper_limit) && $stable(lower_limit))
      else $error("limit changed without a register write");
endmodule // tal_alarm

// *** dv/tal_host.sv ***
// Serial bus host controller model that drives the sensor's clock and data lines
module tal_host (
   output logic scl,     // Serial clock, idles high between frames
   output logic sda_low, // High while the host pulls the data line low
   input wire logic sda  // Resolved data line level
);
   timeunit 1ns;
   timeprecision 1ns;
   // Quarter of a 400 kHz bit; clock high lasts two quarters
   localparam int QTR = 625;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // ----------------------------------------
   // Bit level
   // ----------------------------------------
   // Data only changes while the clock is low
   task automatic bit_out(input logic b);
      sda_low = ~b;
      #QTR scl = 1'b1;
      #(2 * QTR) scl = 1'b0;
      #QTR;
   endtask
   task automatic bit_in(output logic b);
      sda_low = 1'b0;
      #QTR scl = 1'b1;
      #QTR b = sda;
      #QTR scl = 1'b0;
      #QTR;
   endtask
   // ----------------------------------------
   // Framing
   // ----------------------------------------
   // Also serves as a repeated start from inside a frame
   task automatic start();
      sda_low = 1'b0;
      #QTR scl = 1'b1;
      #QTR sda_low = 1'b1;
      #QTR scl = 1'b0;
      #QTR;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #QTR scl = 1'b1;
      #QTR sda_low = 1'b0;
      #(2 * QTR);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(ack);
      ack = ~ack;
   endtask
   // Acks every byte but the last, which gets a nack
   task automatic recv(input logic last, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_in(b);
         d[i] = b;
      end
      bit_out(last);
   endtask
endmodule // tal_host

// *** dv/tal_alarm_test.sv ***
// Self-checking testbench of the temperature alarm and pin address block
module tal_alarm_test
   import tal_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, arst_n, int_ext, trig_ext, start_measure_fn_done, start_measure_fn_start;
   logic scl, sda_low, sda_o, sda_oe, int_o, int_oe, int_pd, trig_o, trig_oe, trig_pd;
   logic [15:0] start_measure_fn_result;
   logic [7:0] cfg;
   int fail_count, n_compared, starts;
   // Pull-up on the data line; pins follow the device whenever it drives them
   wire sda = ~(sda_low | sda_oe);
   wire int_lvl = int_oe ? int_o : int_ext;
   wire trig_lvl = trig_oe ? trig_o : trig_ext;

   tal_host host (.scl(scl), .sda_low(sda_low), .sda(sda));
   tal_alarm uut (.core_clk(core_clk), .arst_n(arst_n), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .int_i(int_lvl), .int_o(int_o), .int_oe(int_oe),
      .int_pd(int_pd), .trig_i(trig_lvl), .trig_o(trig_o), .trig_oe(trig_oe),
      .trig_pd(trig_pd), .start_measure_fn_done(start_measure_fn_done), .start_measure_fn_result(start_measure_fn_result),
      .start_measure_fn_start(start_measure_fn_start));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (start_measure_fn_start === 1'b1) starts <= starts + 1;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A pin in output or function mode reads as 0 in the address
   function automatic logic [7:0] dev_addr(input logic rd);
      return {ADDR_PREFIX, cfg[TRIG_MODE_LSB] ? 1'b0 : trig_lvl,
         cfg[INT_MODE_LSB] ? 1'b0 : int_lvl, rd};
   endfunction
   task automatic wr_reg(input logic [7:0] off, input logic [15:0] d, input int n);
      logic a;
      @(posedge core_clk) #1;
      host.start();
      host.send(dev_addr(1'b0), a);
      chk(16'(a), 16'h0001);
      host.send(off, a);
      for (int i = n - 1; i >= 0; i--) begin
         host.send(d[8 * i +: 8], a);
         chk(16'(a), 16'h0001);
      end
      host.stop();
      if (off == OFF_PIN_CFG) cfg = d[7:0];
   endtask
   // Status is read after a stop, which points at offset 00
   task automatic rd_regs(input logic [7:0] off, input int n, output logic [15:0] v);
      logic a;
      logic [7:0] b;
      v = 16'h0000;
      @(posedge core_clk) #1;
      host.start();
      if (off != OFF_STATUS) begin
         host.send(dev_addr(1'b0), a);
         host.send(off, a);
         host.start();
      end
      host.send(dev_addr(1'b1), a);
      chk(16'(a), 16'h0001);
      for (int i = 0; i < n; i++) begin
         host.recv(i == n - 1, b);
         v = {v[7:0], b};
      end
      host.stop();
   endtask
   task automatic start_measure_fn(input logic [15:0] r);
      @(posedge core_clk) #1;
      start_measure_fn_done = 1'b1;
      start_measure_fn_result = r;
      @(posedge core_clk) #1;
      start_measure_fn_done = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [15:0] v;
      chk(16'({int_pd, trig_pd, int_oe, trig_oe, sda_oe, sda_o, start_measure_fn_start}), 16'h0060);
      rd_regs(OFF_UPPER_HI, 2, v);
      chk(v, 16'h7FFF);
      rd_regs(OFF_LOWER_HI, 2, v);
      chk(v, 16'h8000);
      rd_regs(OFF_PIN_CFG, 1, v);
      chk(v, 16'h0082);
      rd_regs(OFF_STATUS, 1, v);
      chk(v, 16'h0000);
      $display("t_reset done");
   endtask
   task automatic t_addr();
      logic [15:0] v;
      logic a;
      @(posedge core_clk) #1;
      int_ext = 1'b1;
      trig_ext = 1'b1;
      host.start();
      host.send(8'hA0, a);
      chk(16'(a), 16'h0000);
      host.stop();
      wr_reg(OFF_PIN_CFG, 16'h004D, 1);
      chk(16'({int_oe, int_o, trig_oe, trig_o, int_pd, trig_pd}), 16'h003C);
      rd_regs(OFF_PIN_CFG, 1, v);
      chk(v, 16'h004D);
      wr_reg(OFF_PIN_CFG, 16'h0000, 1);
      chk(16'({int_oe, trig_oe, int_pd, trig_pd}), 16'h0000);
      @(posedge core_clk) #1;
      int_ext = 1'b0;
      trig_ext = 1'b0;
      wr_reg(OFF_PIN_CFG, 16'h0082, 1);
      $display("t_addr done");
   endtask
   task automatic t_alarm();
      logic [15:0] v;
      wr_reg(OFF_UPPER_HI, 16'h1000, 2);
      wr_reg(OFF_LOWER_HI, 16'hF000, 2);
      wr_reg(OFF_MASK, 16'h0006, 1);
      wr_reg(OFF_PIN_CFG, 16'h0083, 1);
      start_measure_fn(16'h1000);
      start_measure_fn(16'hF000);
      chk(16'(int_oe), 16'h0000);
      start_measure_fn(16'h1001);
      chk(16'({int_oe, int_o, int_lvl}), 16'h0004);
      start_measure_fn(16'h0000);
      chk(16'(int_oe), 16'h0001);
      rd_regs(OFF_STATUS, 1, v);
      chk(v, 16'h0002);
      chk(16'(int_oe), 16'h0000);
      wr_reg(OFF_MASK, 16'h0002, 1);
      start_measure_fn(16'h8001);
      chk(16'(int_oe), 16'h0000);
      start_measure_fn(16'h1001);
      chk(16'(int_oe), 16'h0001);
      rd_regs(OFF_STATUS, 1, v);
      chk(v, 16'h0006);
      wr_reg(OFF_PIN_CFG, 16'h0082, 1);
      start_measure_fn(16'h1001);
      chk(16'({int_oe, int_pd}), 16'h0001);
      rd_regs(OFF_STATUS, 1, v);
      chk(v, 16'h0002);
      $display("t_alarm done");
   endtask
   task automatic t_trigger();
      @(posedge core_clk) #1;
      trig_ext = 1'b1;
      wr_reg(OFF_PIN_CFG, 16'h00C2, 1);
      for (int m = 0; m < 2; m++) begin
         starts = 0;
         @(posedge core_clk) #1;
         trig_ext = 1'b0;
         repeat (8) @(posedge core_clk);
         #1;
         chk(16'(starts), m == 0 ? 16'h0001 : 16'h0000);
         trig_ext = 1'b1;
         wr_reg(OFF_PIN_CFG, 16'h0082, 1);
      end
      $display("t_trigger done");
   endtask
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      fail_count = 0;
      n_compared = 0;
      starts = 0;
      arst_n = 1'b0;
      int_ext = 1'b0;
      trig_ext = 1'b0;
      start_measure_fn_done = 1'b0;
      start_measure_fn_result = 16'h0000;
      cfg = 8'h82;
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      t_reset();
      t_addr();
      t_alarm();
      t_trigger();
      summarize();
   end
   // The tests need about 1.6 ms of bus traffic
   initial begin
      #6000000;
      fail_count++;
      summarize();
   end
endmodule // tal_alarm_test
